// *** hdl/ccr_pkg.sv ***
// ccr_pkg: constants and carrier types of the charger configuration register bank
// assumes: 8-bit register map reached over a two-wire serial bus, one 40 MHz clock
package ccr_pkg;

    // ==================================================================
    // register map
    localparam logic [7:0] CCR_OFS_POWER_ON   = 8'h01;
    localparam logic [7:0] CCR_OFS_CHG_CUR    = 8'h02;
    localparam logic [7:0] CCR_OFS_PRE_TERM   = 8'h03;
    localparam logic [7:0] CCR_RST_POWER_ON   = 8'h1b;
    localparam logic [7:0] CCR_RST_CHG_CUR    = 8'h20;
    localparam logic [7:0] CCR_RST_PRE_TERM   = 8'h11;
    localparam logic [7:0] CCR_RD_UNMAPPED    = 8'h00;

    // ==================================================================
    // field positions
    localparam int CCR_BIT_SOFT_RESET = 7;
    localparam int CCR_BIT_WDOG_KICK  = 6;
    localparam int CCR_POS_MODE       = 4;
    localparam int CCR_POS_SYSMIN     = 1;
    localparam int CCR_BIT_BOOST      = 0;
    localparam int CCR_POS_FAST       = 2;
    localparam int CCR_BIT_RESERVED   = 1;
    localparam int CCR_BIT_OVERRIDE   = 0;
    localparam int CCR_POS_PRE        = 4;
    localparam int CCR_POS_TERM       = 0;

    // ==================================================================
    // decode constants (mV, mA, percent)
    localparam logic [15:0] CCR_SYSMIN_OFS_MV = 16'd3000;
    localparam logic [15:0] CCR_SYSMIN_LSB_MV = 16'd100;
    localparam logic [15:0] CCR_BOOST_LO_MA   = 16'd500;
    localparam logic [15:0] CCR_BOOST_HI_MA   = 16'd1300;
    localparam logic [15:0] CCR_FAST_OFS_MA   = 16'd512;
    localparam logic [15:0] CCR_FAST_LSB_MA   = 16'd64;
    localparam logic [15:0] CCR_PRE_OFS_MA    = 16'd128;
    localparam logic [15:0] CCR_PRE_LSB_MA    = 16'd128;
    localparam logic [15:0] CCR_TERM_OFS_MA   = 16'd128;
    localparam logic [15:0] CCR_TERM_LSB_MA   = 16'd128;
    localparam logic [15:0] CCR_FAST_RED_PCT  = 16'd20;
    localparam logic [15:0] CCR_PRE_RED_PCT   = 16'd50;
    localparam logic [15:0] CCR_PCT_FULL      = 16'd100;

    // ==================================================================
    // operating modes
    localparam logic [1:0] CCR_MODE_OFF    = 2'h0;
    localparam logic [1:0] CCR_MODE_CHARGE = 2'h1;

    // serial bus address (arbitrary value)
    localparam logic [6:0] CCR_DEV_ADDR = 7'h5a;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic [1:0] operating_mode_select;
        logic [2:0] minimum_system_voltage;
        logic       boost_current_limit;
        logic [5:0] fast_charge_current_code;
        logic       reduced_current_override;
        logic [3:0] precharge_current_code;
        logic [3:0] termination_current_code;
    } ccr_fields_t;

    typedef struct packed {
        logic [1:0]  mode;
        logic        boost_on;
        logic [15:0] sysmin_mv;
        logic [15:0] boost_ma;
        logic [15:0] fast_ma;
        logic [15:0] pre_ma;
        logic [15:0] term_ma;
    } ccr_limits_t;

endpackage : ccr_pkg

// *** hdl/ccr_field_decode.sv ***
// ccr_field_decode: turns register fields into applied limits in mV and mA
// assumes: fields come from flip-flops of the register bank, same clock
`timescale 1ns/10ps
module ccr_field_decode (
    input  wire logic                 clk,    // 40 MHz clock
    input  wire logic                 nrst,   // sync reset, active low
    input  wire ccr_pkg::ccr_fields_t fields, // stored register fields
    output ccr_pkg::ccr_limits_t      limits  // applied limits, registered
);
    import ccr_pkg::*;

    typedef struct packed {
        ccr_limits_t lim;
    } ccr_dec_state_t;

    ccr_dec_state_t s_r;
    ccr_dec_state_t s_nxt;
    logic [15:0]    fast_full;
    logic [15:0]    pre_full;

    // ==================================================================
    // decode
    always_comb begin
        fast_full = CCR_FAST_OFS_MA + 16'(fields.fast_charge_current_code) * CCR_FAST_LSB_MA;
        pre_full  = CCR_PRE_OFS_MA + 16'(fields.precharge_current_code) * CCR_PRE_LSB_MA;
        s_nxt              = s_r;
        s_nxt.lim.mode     = fields.operating_mode_select;
        s_nxt.lim.boost_on = fields.operating_mode_select[1];
        s_nxt.lim.sysmin_mv = CCR_SYSMIN_OFS_MV
                            + 16'(fields.minimum_system_voltage) * CCR_SYSMIN_LSB_MV;
        s_nxt.lim.boost_ma = fields.boost_current_limit ? CCR_BOOST_HI_MA
                                                        : CCR_BOOST_LO_MA;
        if (fields.reduced_current_override) begin
            s_nxt.lim.fast_ma = 16'((32'(fast_full) * 32'(CCR_FAST_RED_PCT))
                                    / 32'(CCR_PCT_FULL));
            s_nxt.lim.pre_ma  = 16'((32'(pre_full) * 32'(CCR_PRE_RED_PCT))
                                    / 32'(CCR_PCT_FULL));
        end else begin
            s_nxt.lim.fast_ma = fast_full;
            s_nxt.lim.pre_ma  = pre_full;
        end
        s_nxt.lim.term_ma = CCR_TERM_OFS_MA
                          + 16'(fields.termination_current_code) * CCR_TERM_LSB_MA;
        if (!nrst) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign limits = s_r.lim;

    // ==================================================================
    // checks
    boost_decode_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 $past(nrst) |-> limits.boost_ma ==
            ($past(fields.boost_current_limit) ? 16'd1300 : 16'd500))
        else $error("boost limit decode wrong");

    fast_reduce_a: assert property (@(posedge clk) disable iff (!nrst)
        fields.reduced_current_override && fields.fast_charge_current_code == 6'h08
        |=> limits.fast_ma == 16'd204)
        else $error("reduced fast charge current wrong");

    sysmin_decode_a: assert property (@(posedge clk) disable iff (!nrst)
        fields.minimum_system_voltage == 3'h5 |=> limits.sysmin_mv == 16'd3500)
        else $error("minimum system voltage decode wrong");

endmodule : ccr_field_decode

// *** hdl/ccr_config_regs.sv ***
// ccr_config_regs: charger configuration registers behind a two-wire serial slave
// assumes: scl and sda inputs are already synchronous to clk; sda is open drain
// Operation
// - writing 1 to bit 7 of the power-on register restores all registers to defaults and it reads 0.
// - writing 1 to bit 6 of the power-on register restarts the watchdog and the bit reads 0.
// - bits 5:4 pick off (00), charge (01, default) or boost (10/11).
// - bits 3:1 give minimum system voltage 3.0 V plus 0.1 V steps, default 101 (3.5 V).
// - bit 0 of the power-on register picks 500 mA (0) or 1.3 A (1) boost limit, reset 1.
// - bits 7:2 of the charge current register give 512 mA plus 64 mA steps, reset 0x20.
// - override bit 0 set applies 20 % fast and 50 % pre-charge current, clear applies them as set.
// - the pre-charge/termination register holds two 4-bit read/write codes and resets to 0x11.
// - the power-on register resets to 0x1b.
// - pre-charge code means 128 mA plus 128 mA steps, default 256 mA.
// - termination code means 128 mA plus 128 mA steps, default 256 mA.
`timescale 1ns/10ps
module ccr_config_regs (
    input  wire logic            clk,      // 40 MHz clock
    input  wire logic            nrst,     // sync reset, active low
    input  wire logic            scl_i,    // serial clock level
    input  wire logic            sda_i,    // serial data level
    output logic                 sda_o,    // serial data drive value, always low
    output logic                 sda_oe,   // high while pulling sda low
    output logic                 wdog_kick, // one-cycle watchdog restart pulse
    output ccr_pkg::ccr_limits_t limits    // applied limits
);
    import ccr_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR, S_WR, S_ACK_WR, S_RD, S_ACK_RD
    } ccr_bus_st_t;

    typedef struct packed {
        ccr_bus_st_t st;
        logic [2:0]  cnt;
        logic        done;
        logic [7:0]  sh;
        logic        rnw;
        logic        nack;
        logic [7:0]  ptr;
        logic        oe;
        logic        scl_p;
        logic        sda_p;
        logic        kick;
        ccr_fields_t f;
    } ccr_state_t;

    ccr_state_t  s_r;
    ccr_state_t  s_nxt;
    ccr_fields_t f_dflt;
    logic        start_c;
    logic        stop_c;
    logic        rise_c;
    logic        fall_c;
    logic [7:0]  rd_data;
    logic        wr_c;

    // ==================================================================
    // defaults and read mux
    assign f_dflt = '{operating_mode_select:    CCR_RST_POWER_ON[CCR_POS_MODE +: 2],
                      minimum_system_voltage:   CCR_RST_POWER_ON[CCR_POS_SYSMIN +: 3],
                      boost_current_limit:      CCR_RST_POWER_ON[CCR_BIT_BOOST],
                      fast_charge_current_code: CCR_RST_CHG_CUR[CCR_POS_FAST +: 6],
                      reduced_current_override: CCR_RST_CHG_CUR[CCR_BIT_OVERRIDE],
                      precharge_current_code:   CCR_RST_PRE_TERM[CCR_POS_PRE +: 4],
                      termination_current_code: CCR_RST_PRE_TERM[CCR_POS_TERM +: 4]};

    function automatic logic [7:0] reg_read(input logic [7:0] a, input ccr_fields_t f);
        logic [7:0] d;
        d = CCR_RD_UNMAPPED;
        case (a)
            CCR_OFS_POWER_ON: d = {2'b00, f.operating_mode_select,
                                   f.minimum_system_voltage, f.boost_current_limit};
            CCR_OFS_CHG_CUR:  d = {f.fast_charge_current_code, 1'b0,
                                   f.reduced_current_override};
            CCR_OFS_PRE_TERM: d = {f.precharge_current_code, f.termination_current_code};
            default:          d = CCR_RD_UNMAPPED;
        endcase
        return d;
    endfunction : reg_read

    assign rd_data = reg_read(s_r.ptr, s_r.f);
    assign start_c = s_r.scl_p && scl_i && s_r.sda_p && !sda_i;
    assign stop_c  = s_r.scl_p && scl_i && !s_r.sda_p && sda_i;
    assign rise_c  = scl_i && !s_r.scl_p;
    assign fall_c  = !scl_i && s_r.scl_p;
    assign wr_c    = fall_c && s_r.st == S_WR && s_r.done;

    // ==================================================================
    // bus engine and register file
    always_comb begin
        s_nxt       = s_r;
        s_nxt.scl_p = scl_i;
        s_nxt.sda_p = sda_i;
        s_nxt.kick  = 1'b0;
        if (start_c) begin
            s_nxt.st   = S_ADDR;
            s_nxt.cnt  = 3'h0;
            s_nxt.done = 1'b0;
            s_nxt.oe   = 1'b0;
        end else if (stop_c) begin
            s_nxt.st = S_IDLE;
            s_nxt.oe = 1'b0;
        end else begin
            case (s_r.st)
                S_ADDR, S_PTR, S_WR: begin
                    if (rise_c) begin
                        s_nxt.sh   = {s_r.sh[6:0], sda_i};
                        s_nxt.cnt  = s_r.cnt + 3'h1;
                        s_nxt.done = (s_r.cnt == 3'h7);
                    end else if (fall_c && s_r.done) begin
                        s_nxt.done = 1'b0;
                        s_nxt.oe   = 1'b1;
                        if (s_r.st == S_ADDR) begin
                            s_nxt.rnw = s_r.sh[0];
                            s_nxt.st  = S_ACK_ADDR;
                            if (s_r.sh[7:1] != CCR_DEV_ADDR) begin
                                s_nxt.st = S_IDLE;
                                s_nxt.oe = 1'b0;
                            end
                        end else if (s_r.st == S_PTR) begin
                            s_nxt.ptr = s_r.sh;
                            s_nxt.st  = S_ACK_PTR;
                        end else begin
                            s_nxt.st = S_ACK_WR;
                        end
                    end
                end
                S_ACK_ADDR, S_ACK_PTR, S_ACK_WR: begin
                    if (fall_c) begin
                        s_nxt.oe  = 1'b0;
                        s_nxt.cnt = 3'h0;
                        s_nxt.st  = (s_r.st == S_ACK_ADDR) ? S_PTR : S_WR;
                        if (s_r.st == S_ACK_WR) begin
                            s_nxt.ptr = s_r.ptr + 8'h01;
                        end
                        if (s_r.st == S_ACK_ADDR && s_r.rnw) begin
                            s_nxt.st = S_RD;
                            s_nxt.sh = rd_data;
                            s_nxt.oe = !rd_data[7];
                        end
                    end
                end
                S_RD: begin
                    if (rise_c) begin
                        s_nxt.cnt  = s_r.cnt + 3'h1;
                        s_nxt.done = (s_r.cnt == 3'h7);
                    end else if (fall_c && s_r.done) begin
                        s_nxt.done = 1'b0;
                        s_nxt.oe   = 1'b0;
                        s_nxt.ptr  = s_r.ptr + 8'h01;
                        s_nxt.st   = S_ACK_RD;
                    end else if (fall_c) begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.oe = !s_r.sh[6];
                    end
                end
                S_ACK_RD: begin
                    if (rise_c) begin
                        s_nxt.nack = sda_i;
                    end else if (fall_c) begin
                        s_nxt.cnt = 3'h0;
                        if (s_r.nack) begin
                            s_nxt.st = S_IDLE;
                        end else begin
                            s_nxt.st = S_RD;
                            s_nxt.sh = rd_data;
                            s_nxt.oe = !rd_data[7];
                        end
                    end
                end
                default: begin
                    s_nxt.oe = 1'b0;
                end
            endcase
        end
        // register writes land when the data byte is acknowledged
        if (wr_c) begin
            case (s_r.ptr)
                CCR_OFS_POWER_ON: begin
                    if (s_r.sh[CCR_BIT_SOFT_RESET]) begin
                        s_nxt.f = f_dflt;
                    end else begin
                        s_nxt.f.operating_mode_select  = s_r.sh[CCR_POS_MODE +: 2];
                        s_nxt.f.minimum_system_voltage = s_r.sh[CCR_POS_SYSMIN +: 3];
                        s_nxt.f.boost_current_limit    = s_r.sh[CCR_BIT_BOOST];
                    end
                    s_nxt.kick = s_r.sh[CCR_BIT_WDOG_KICK];
                end
                CCR_OFS_CHG_CUR: begin
                    s_nxt.f.fast_charge_current_code = s_r.sh[CCR_POS_FAST +: 6];
                    s_nxt.f.reduced_current_override = s_r.sh[CCR_BIT_OVERRIDE];
                end
                CCR_OFS_PRE_TERM: begin
                    s_nxt.f.precharge_current_code   = s_r.sh[CCR_POS_PRE +: 4];
                    s_nxt.f.termination_current_code = s_r.sh[CCR_POS_TERM +: 4];
                end
                default: begin
                    s_nxt.kick = 1'b0;
                end
            endcase
        end
        if (!nrst) begin
            s_nxt       = '0;
            s_nxt.st    = S_IDLE;
            s_nxt.scl_p = 1'b1;
            s_nxt.sda_p = 1'b1;
            s_nxt.nack  = 1'b1;
            s_nxt.f     = f_dflt;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign sda_o     = 1'b0;
    assign sda_oe    = s_r.oe;
    assign wdog_kick = s_r.kick;

    ccr_field_decode u_decode (
        .clk    (clk),
        .nrst   (nrst),
        .fields (s_r.f),
        .limits (limits)
    );

    // ==================================================================
    // checks
    sequence s_wr_poc;
        wr_c && s_r.ptr == 8'h01;
    endsequence

    soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        s_wr_poc ##0 s_r.sh[7] |=> reg_read(8'h01, s_r.f) == 8'h1b
            && reg_read(8'h02, s_r.f) == 8'h20 && reg_read(8'h03, s_r.f) == 8'h11)
        else $error("register reset did not restore defaults");

    kick_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        s_wr_poc ##0 s_r.sh[6] |=> wdog_kick ##1 !wdog_kick
            && (reg_read(8'h01, s_r.f) & 8'h40) == 8'h00)
        else $error("watchdog kick not a single pulse");

    mode_store_a: assert property (@(posedge clk) disable iff (!nrst)
        s_wr_poc ##0 !s_r.sh[7] |=> s_r.f.operating_mode_select == $past(s_r.sh[5:4]))
        else $error("operating mode not stored");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_c && s_r.ptr == 8'h02 |=> (reg_read(8'h02, s_r.f) & 8'h02) == 8'h00)
        else $error("reserved bit reads nonzero");

    pre_term_store_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_c && s_r.ptr == 8'h03 |=> reg_read(8'h03, s_r.f) == $past(s_r.sh))
        else $error("pre-charge/termination register not stored");

    fast_store_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_c && s_r.ptr == 8'h02 |=> s_r.f.fast_charge_current_code == $past(s_r.sh[7:2]))
        else $error("fast charge code not stored");

    reset_value_a: assert property (@(posedge clk)
        !nrst |=> reg_read(8'h01, s_r.f) == 8'h1b && reg_read(8'h03, s_r.f) == 8'h11)
        else $error("reset values wrong");

endmodule : ccr_config_regs

// *** tb/ccr_host_model.sv ***
// ccr_host_model: host side of the two-wire register bus
// assumes: sda_in is the resolved wire with a pull-up, tasks are entered just after a clk edge
`timescale 1ns/10ps
module ccr_host_model (
    input  wire logic clk,           // bench clock
    input  wire logic sda_in,        // resolved data line
    output logic      scl,           // serial clock, idle high
    output logic      sda_drive_low  // high while host pulls sda low
);
    initial begin
        scl = 1'b1;
        sda_drive_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // data changes only while scl is low; sampled late in the high phase
    task automatic one_bit(input logic low, output logic seen);
        scl <= 1'b0;
        tick(1);
        sda_drive_low <= low;
        tick(3);
        scl <= 1'b1;
        tick(3);
        seen = sda_in;
        tick(1);
    endtask : one_bit

    task automatic start_c();
        scl <= 1'b0;
        tick(1);
        sda_drive_low <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_drive_low <= 1'b1;
        tick(4);
    endtask : start_c

    task automatic stop_c();
        scl <= 1'b0;
        tick(1);
        sda_drive_low <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_drive_low <= 1'b0;
        tick(4);
    endtask : stop_c

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(!b[i], s);
        end
        one_bit(1'b0, s);
        ack = !s;
    endtask : put_byte

    task automatic get_byte(output logic [7:0] b, input logic more);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b0, s);
            b[i] = s;
        end
        one_bit(more, s);
    endtask : get_byte
endmodule : ccr_host_model

// *** tb/ccr_config_regs_tb_top.sv ***
// ccr_config_regs_tb_top: self-checking bench of the configuration register bank
// assumes: ccr_pkg, ccr_config_regs and ccr_host_model are compiled first
`timescale 1ns/10ps
module ccr_config_regs_tb_top import ccr_pkg::*; ;
    logic        clk, nrst, host_low, scl, sda_o, sda_oe, wdog_kick, ack;
    wire logic   sda;
    ccr_limits_t limits;
    int          num_errors, comparisons, kicks;
    logic [31:0] rng;
    logic [7:0]  wbuf [0:2];
    logic [7:0]  rbuf [0:2];
    logic [7:0]  r1, r2, r3;

    // open-drain wire with pull-up
    assign sda = !((sda_oe && !sda_o) || host_low);

    ccr_config_regs DUT (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .wdog_kick(wdog_kick), .limits(limits));
    ccr_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_drive_low(host_low));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (wdog_kick === 1'b1) kicks <= kicks + 1;
    end

    // ==================================================================
    // helpers
    function automatic logic [7:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic head(input logic [7:0] ptr);
        host.start_c();
        host.put_byte({CCR_DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b1, "address ack");
        host.put_byte(ptr, ack);
        check(ack, 1'b1, "pointer ack");
    endtask : head

    task automatic bus_write(input logic [7:0] ptr, input int n);
        head(ptr);
        for (int i = 0; i < n; i++) begin
            host.put_byte(wbuf[i], ack);
            check(ack, 1'b1, "data ack");
        end
        host.stop_c();
        host.tick(4);
    endtask : bus_write

    task automatic bus_read(input logic [7:0] ptr, input int n);
        head(ptr);
        host.start_c();
        host.put_byte({CCR_DEV_ADDR, 1'b1}, ack);
        check(ack, 1'b1, "read address ack");
        for (int i = 0; i < n; i++) begin
            host.get_byte(rbuf[i], i < n - 1);
        end
        host.stop_c();
    endtask : bus_read

    task automatic check_regs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        bus_read(CCR_OFS_POWER_ON, 3);
        check(rbuf[0], a, "power-on register");
        check(rbuf[1], b, "charge current register");
        check(rbuf[2], c, "pre-charge register");
    endtask : check_regs

    task automatic check_limits(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        int fast, pre;
        fast = 512 + 64 * b[7:2];
        pre = 128 + 128 * c[7:4];
        if (b[0]) begin
            fast = fast * 20 / 100;
            pre = pre * 50 / 100;
        end
        check(limits.mode, a[5:4], "mode");
        check(limits.boost_on, a[5], "boost select");
        check(limits.sysmin_mv, 3000 + 100 * a[3:1], "minimum system voltage");
        check(limits.boost_ma, a[0] ? 1300 : 500, "boost limit");
        check(limits.fast_ma, fast, "fast charge current");
        check(limits.pre_ma, pre, "pre-charge current");
        check(limits.term_ma, 128 + 128 * c[3:0], "termination current");
    endtask : check_limits

    // ==================================================================
    // main sequence
    initial begin
        rng = 32'd91;
        num_errors = 0;
        comparisons = 0;
        kicks = 0;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        host.tick(2);
        check_limits(8'h1b, 8'h20, 8'h11);
        check_regs(8'h1b, 8'h20, 8'h11);
        for (int k = 0; k < 8; k++) begin
            r1 = xs();
            r1[7:4] = {2'b00, k[1:0]};
            r2 = xs();
            r2[1] = 1'b0;
            r3 = xs();
            if (k == 6) begin
                // default fast code with the override set
                r1[3:0] = 4'h0;
                r2 = 8'h21;
            end
            if (k == 7) begin
                r2 = 8'hfd;
                r3 = 8'hff;
            end
            wbuf[0] = r1;
            wbuf[1] = r2;
            wbuf[2] = r3;
            bus_write(CCR_OFS_POWER_ON, 3);
            check_limits(r1, r2, r3);
            check_regs(r1, r2, r3);
        end
        check(kicks, 0, "kick without request");
        wbuf[0] = 8'h6a;
        bus_write(CCR_OFS_POWER_ON, 1);
        check(kicks, 1, "watchdog kick");
        check_regs(8'h2a, r2, r3);
        wbuf[0] = 8'ha4;
        bus_write(CCR_OFS_POWER_ON, 1);
        check_limits(8'h1b, 8'h20, 8'h11);
        check_regs(8'h1b, 8'h20, 8'h11);
        check(kicks, 1, "kick on register reset");
        wbuf[0] = 8'h5c;
        wbuf[1] = 8'hff;
        wbuf[2] = 8'hff;
        bus_write(CCR_OFS_PRE_TERM, 3);
        bus_read(8'h04, 2);
        check(rbuf[0], 8'h00, "unmapped read");
        check(rbuf[1], 8'h00, "unmapped read");
        check_regs(8'h1b, 8'h20, 8'h5c);
        host.start_c();
        host.put_byte({CCR_DEV_ADDR ^ 7'h01, 1'b0}, ack);
        check(ack, 1'b0, "foreign address ack");
        host.stop_c();
        // reset in mid-run restores every register
        nrst <= 1'b0;
        host.tick(3);
        nrst <= 1'b1;
        host.tick(2);
        check_limits(8'h1b, 8'h20, 8'h11);
        check_regs(8'h1b, 8'h20, 8'h11);
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule : ccr_config_regs_tb_top
